// File: rtl/rap_pkg.sv
// Package: constants, register map and carrier types of the alarm and periodic interrupt unit
package rap_pkg;

	// System clock rate
	localparam int unsigned CLK_HZ      = 20_000_000;
	localparam int unsigned CLK_PER_US  = CLK_HZ / 1_000_000;

	// Seconds increment trails the pulse falling edge (in ns, rounded down)
	localparam int unsigned INC_DELAY_NS     = 92_000;
	localparam int unsigned INC_DELAY_CYCLES = INC_DELAY_NS * CLK_PER_US / 1000;

	// Largest oscillation-adjust correction (in us) and its cycle count
	localparam int unsigned ADJ_MAX_US     = 3784;
	localparam int unsigned ADJ_MAX_CYCLES = ADJ_MAX_US * CLK_PER_US;

	// Adjust is applied once every this many seconds
	localparam int unsigned ADJ_PERIOD_SEC = 20;

	// Register offsets
	localparam logic [3:0] ADDR_CTRL_ONE   = 4'hE;
	localparam logic [3:0] ADDR_STATUS_TWO = 4'hF;

	// Field positions, interrupt_control_one
	localparam int WEEKLY_EN_BIT = 7;
	localparam int DAILY_EN_BIT  = 6;
	localparam int AUX_HI_BIT    = 5;
	localparam int AUX_LO_BIT    = 3;
	localparam int SEL_HI_BIT    = 2;
	localparam int SEL_LO_BIT    = 0;

	// Field positions, interrupt_status_two
	localparam int PERIODIC_FLAG_BIT = 2;
	localparam int WEEKLY_FLAG_BIT   = 1;
	localparam int DAILY_FLAG_BIT    = 0;

	// Reset values
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] READ_ZERO    = 8'h00;

	// Periodic select codes
	localparam logic [2:0] SEL_OFF      = 3'h0;
	localparam logic [2:0] SEL_LOW      = 3'h1;
	localparam logic [2:0] SEL_PULSE_2  = 3'h2;
	localparam logic [2:0] SEL_PULSE_1  = 3'h3;
	localparam logic [2:0] SEL_LVL_SEC  = 3'h4;
	localparam logic [2:0] SEL_LVL_MIN  = 3'h5;
	localparam logic [2:0] SEL_LVL_HOUR = 3'h6;
	localparam logic [2:0] SEL_LVL_MON  = 3'h7;

	// BCD constants for period matches
	localparam logic [6:0] BCD_ZERO7 = 7'h00;
	localparam logic [5:0] BCD_ZERO6 = 6'h00;
	localparam logic [5:0] BCD_ONE6  = 6'h01;

	// Current time from the timekeeping counters, BCD
	typedef struct packed {
		logic [2:0] day_of_week;
		logic [5:0] hour;
		logic [6:0] minute;
		logic [6:0] second;
		logic [5:0] day_of_month;
	} rap_time_t;

	// Alarm register contents, BCD
	typedef struct packed {
		logic [6:0] weekday_mask;
		logic [5:0] hour;
		logic [6:0] minute;
	} rap_alarm_t;

	// Sub-second divider phases
	typedef struct packed {
		logic low_1hz;
		logic low_2hz;
		logic sec_inc;
	} rap_phase_t;

endpackage

// File: rtl/rap_sticky_flag.sv
// Sticky event flag: hardware set, software clear, set wins the tie
`timescale 1ns/1ps
`default_nettype none

module rap_sticky_flag
	import rap_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic nrst_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	input  wire logic halt_i,
	output logic      flag_o
);

	logic flag_q;

	// Halt clears all; an event in the clear cycle is kept
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flag_q <= 1'b0;
		end else if (halt_i) begin
			flag_q <= 1'b0;
		end else if (set_i) begin
			flag_q <= 1'b1;
		end else if (clr_i) begin
			flag_q <= 1'b0;
		end
	end

	assign flag_o = flag_q;

endmodule

`default_nettype wire

// File: rtl/rap_subsec_div.sv
// Sub-second divider: second phase, 1 Hz and 2 Hz low phases, seconds increment
`timescale 1ns/1ps
`default_nettype none

module rap_subsec_div
	import rap_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = CLK_HZ,
	parameter int unsigned CW         = 26
) (
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        restart_i,
	input  wire logic        adj_en_i,
	input  wire logic [17:0] adj_cycles_i,
	output var rap_phase_t   phase_o
);

	localparam logic [CW-1:0] SEC_LEN  = CW'(SEC_CYCLES);
	localparam logic [CW-1:0] HALF_LEN = CW'(SEC_CYCLES / 2);
	localparam logic [CW-1:0] QTR_LEN  = CW'(SEC_CYCLES / 4);
	localparam logic [CW-1:0] INC_AT   = CW'(INC_DELAY_CYCLES);
	localparam logic [17:0]   ADJ_LIM  = 18'(ADJ_MAX_CYCLES);
	localparam logic [4:0]    ADJ_LAST = 5'(ADJ_PERIOD_SEC - 1);

	logic [CW-1:0] cnt_q;
	logic [4:0]    adj_sec_q;
	logic signed [17:0] adj_lim;
	logic [CW-1:0] low_len;
	logic [CW-1:0] sec_len;
	logic          adj_now;

	// Clamp the correction to its largest documented size
	always_comb begin
		adj_lim = $signed(adj_cycles_i);
		if (adj_lim > $signed(ADJ_LIM)) begin
			adj_lim = $signed(ADJ_LIM);
		end else if (adj_lim < -$signed(ADJ_LIM)) begin
			adj_lim = -$signed(ADJ_LIM);
		end
	end

	// Once per period the low half stretches or shrinks, and so does the second
	assign adj_now = adj_en_i && (adj_sec_q == ADJ_LAST);
	assign low_len = adj_now ? HALF_LEN + CW'(adj_lim) : HALF_LEN;
	assign sec_len = adj_now ? SEC_LEN + CW'(adj_lim) : SEC_LEN;

	// Phase counter; a seconds write restarts it at the falling edge
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= '0;
		end else if (restart_i || cnt_q >= sec_len - CW'(1)) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

	// Counts seconds toward the next adjusted one
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			adj_sec_q <= '0;
		end else if (!restart_i && cnt_q >= sec_len - CW'(1)) begin
			adj_sec_q <= (adj_sec_q == ADJ_LAST) ? 5'h00 : adj_sec_q + 5'h01;
		end
	end

	// Low phases; increment trails the falling edge
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phase_o <= '0;
		end else begin
			phase_o.low_1hz <= (cnt_q < low_len);
			phase_o.low_2hz <= (cnt_q < QTR_LEN) ||
				(cnt_q >= HALF_LEN && cnt_q < HALF_LEN + QTR_LEN);
			phase_o.sec_inc <= (cnt_q == INC_AT) && !restart_i;
		end
	end

endmodule

`default_nettype wire

// File: rtl/rap_alarm_periodic.sv
// Alarm and periodic interrupt unit: one control and one status register, alarms, periodic output
`timescale 1ns/1ps
`default_nettype none

module rap_alarm_periodic
	import rap_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = CLK_HZ
) (
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic [7:0]       reg_rdata_o,
	input  wire rap_time_t   time_i,
	input  wire rap_alarm_t  alarm_weekly_i,
	input  wire rap_alarm_t  alarm_daily_i,
	input  wire logic        sec_write_i,
	input  wire logic        osc_halt_flag_i,
	input  wire logic        adj_en_i,
	input  wire logic [17:0] adj_cycles_i,
	output logic             sec_inc_o,
	input  wire logic        interrupt_out_n_i,
	output logic             interrupt_out_n_o,
	output logic             interrupt_out_n_oe_o,
	output logic             pin_level_o
);

	// Register state
	logic       weekly_alarm_enable_q;
	logic       daily_alarm_enable_q;
	logic [2:0] aux_bits_q;
	logic [2:0] periodic_select_q;

	// Flags
	logic weekly_alarm_flag;
	logic daily_alarm_flag;
	logic level_flag;

	// Match tracking
	logic weekly_match;
	logic daily_match;
	logic weekly_match_q;
	logic daily_match_q;

	// Periodic path
	rap_phase_t phase;
	logic       eval_q;
	logic       period_hit;
	logic       pulse_low;
	logic       periodic_low;
	logic       periodic_flag;

	// Halt edge and write decode
	logic halt_q;
	logic halt_evt;
	logic wr_ctrl;
	logic wr_stat;

	// Pin readback sampler
	logic [2:0] pin_sync_q;
	logic       pin_level_q;

	// Register write decode, shared by both registers
	function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] target);
		reg_hit = (addr == target);
	endfunction

	// Host clear of one status flag: a write with that bit at 0; a 1 leaves it alone
	function automatic logic flag_clear(input logic wr, input logic [7:0] data, input int bit_pos);
		flag_clear = wr && !data[bit_pos];
	endfunction

	// Hour and minute equality, the part both alarms share
	function automatic logic hm_match(input rap_alarm_t alarm, input rap_time_t now);
		hm_match = (alarm.hour == now.hour) && (alarm.minute == now.minute);
	endfunction

	// Weekday mask lookup; a day code past the mask never matches instead of reading unknown
	function automatic logic day_selected(input logic [6:0] mask, input logic [2:0] day);
		day_selected = 1'b0;
		for (int i = 0; i < $bits(mask); i++) begin
			if (int'(day) == i) begin
				day_selected = mask[i];
			end
		end
	endfunction

	// Period boundaries, each built on the one below it
	function automatic logic top_of_minute(input rap_time_t now);
		top_of_minute = (now.second == BCD_ZERO7);
	endfunction

	function automatic logic top_of_hour(input rap_time_t now);
		top_of_hour = top_of_minute(now) && (now.minute == BCD_ZERO7);
	endfunction

	function automatic logic top_of_month(input rap_time_t now);
		top_of_month = top_of_hour(now) && (now.hour == BCD_ZERO6) && (now.day_of_month == BCD_ONE6);
	endfunction

	assign wr_ctrl = reg_wr_i && reg_hit(reg_addr_i, ADDR_CTRL_ONE);
	assign wr_stat = reg_wr_i && reg_hit(reg_addr_i, ADDR_STATUS_TWO);

	// A recorded halt acts once, on its rising edge
	// Acting on the level would also wipe writes made while the flag stays set
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			halt_q <= 1'b0;
		end else begin
			halt_q <= osc_halt_flag_i;
		end
	end

	assign halt_evt = osc_halt_flag_i && !halt_q;

	// Alarm enables, stored apart from the flags
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			weekly_alarm_enable_q <= CTRL_ONE_RST[WEEKLY_EN_BIT];
			daily_alarm_enable_q  <= CTRL_ONE_RST[DAILY_EN_BIT];
		end else if (halt_evt) begin
			weekly_alarm_enable_q <= 1'b0;
			daily_alarm_enable_q  <= 1'b0;
		end else if (wr_ctrl) begin
			weekly_alarm_enable_q <= reg_wdata_i[WEEKLY_EN_BIT];
			daily_alarm_enable_q  <= reg_wdata_i[DAILY_EN_BIT];
		end
	end

	// Periodic select and spare control bits
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			periodic_select_q <= CTRL_ONE_RST[SEL_HI_BIT:SEL_LO_BIT];
			aux_bits_q        <= CTRL_ONE_RST[AUX_HI_BIT:AUX_LO_BIT];
		end else if (halt_evt) begin
			periodic_select_q <= SEL_OFF;
			aux_bits_q        <= '0;
		end else if (wr_ctrl) begin
			periodic_select_q <= reg_wdata_i[SEL_HI_BIT:SEL_LO_BIT];
			aux_bits_q        <= reg_wdata_i[AUX_HI_BIT:AUX_LO_BIT];
		end
	end

	// Weekly compares weekday mask, hour, minute
	assign weekly_match = weekly_alarm_enable_q &&
		day_selected(alarm_weekly_i.weekday_mask, time_i.day_of_week) &&
		hm_match(alarm_weekly_i, time_i);

	// Daily ignores the weekday
	assign daily_match = daily_alarm_enable_q && hm_match(alarm_daily_i, time_i);

	// Flags set on the match edge, so a cleared flag waits for the next match
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			weekly_match_q <= 1'b0;
			daily_match_q  <= 1'b0;
		end else begin
			weekly_match_q <= weekly_match;
			daily_match_q  <= daily_match;
		end
	end

	// Weekly flag: write 0 clears, write 1 ignored
	rap_sticky_flag u_weekly_flag (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.set_i     (weekly_match && !weekly_match_q),
		.clr_i     (flag_clear(wr_stat, reg_wdata_i, WEEKLY_FLAG_BIT)),
		.halt_i    (halt_evt),
		.flag_o    (weekly_alarm_flag)
	);

	// Daily flag, same behaviour
	rap_sticky_flag u_daily_flag (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.set_i     (daily_match && !daily_match_q),
		.clr_i     (flag_clear(wr_stat, reg_wdata_i, DAILY_FLAG_BIT)),
		.halt_i    (halt_evt),
		.flag_o    (daily_alarm_flag)
	);

	// Sub-second divider; owns the seconds increment
	rap_subsec_div #(
		.SEC_CYCLES (SEC_CYCLES)
	) u_div (
		.sys_clk_i    (sys_clk_i),
		.nrst_i       (nrst_i),
		.restart_i    (sec_write_i),
		.adj_en_i     (adj_en_i),
		.adj_cycles_i (adj_cycles_i),
		.phase_o      (phase)
	);

	assign sec_inc_o = phase.sec_inc;

	// Counters settle one cycle after the increment, then the period is judged
	// Judging on the increment itself would compare the old seconds value
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			eval_q <= 1'b0;
		end else begin
			eval_q <= phase.sec_inc;
		end
	end

	// Period boundaries for level mode
	always_comb begin
		period_hit = 1'b0;
		case (periodic_select_q)
			SEL_LVL_SEC: begin
				period_hit = eval_q;
			end
			SEL_LVL_MIN: begin
				period_hit = eval_q && top_of_minute(time_i);
			end
			SEL_LVL_HOUR: begin
				period_hit = eval_q && top_of_hour(time_i);
			end
			SEL_LVL_MON: begin
				period_hit = eval_q && top_of_month(time_i);
			end
			default: begin
				period_hit = 1'b0;
			end
		endcase
	end

	// Level flag holds low until written 0, until a non-level select code is set, or until halt
	rap_sticky_flag u_level_flag (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.set_i     (period_hit),
		.clr_i     (flag_clear(wr_stat, reg_wdata_i, PERIODIC_FLAG_BIT) || !periodic_select_q[2]),
		.halt_i    (halt_evt),
		.flag_o    (level_flag)
	);

	// Periodic waveform by select code
	always_comb begin
		pulse_low = 1'b0;
		case (periodic_select_q)
			SEL_OFF: begin
				pulse_low = 1'b0;
			end
			SEL_LOW: begin
				pulse_low = 1'b1;
			end
			SEL_PULSE_2: begin
				pulse_low = phase.low_2hz;
			end
			SEL_PULSE_1: begin
				pulse_low = phase.low_1hz;
			end
			default: begin
				pulse_low = 1'b0;
			end
		endcase
	end

	// Level mode follows its flag, other modes the waveform
	assign periodic_low  = periodic_select_q[2] ? level_flag : pulse_low;
	assign periodic_flag = periodic_low;

	// Any source pulls the shared line; released when all idle
	// Registered so the pin cannot glitch while sources change in the same cycle
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			interrupt_out_n_oe_o <= 1'b0;
		end else begin
			interrupt_out_n_oe_o <= weekly_alarm_flag || daily_alarm_flag || periodic_low;
		end
	end

	// Open drain: only ever drives low
	assign interrupt_out_n_o = 1'b0;

	// Line level readback, three-stage sampled
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_sync_q <= 3'h7;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], interrupt_out_n_i};
		end
	end

	// Level changes only once the last two stages agree
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_level_q <= 1'b1;
		end else if (pin_sync_q[2] == pin_sync_q[1]) begin
			pin_level_q <= pin_sync_q[2];
		end
	end

	assign pin_level_o = pin_level_q;

	// Read data registered one cycle after the strobe; flags show the source
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= READ_ZERO;
		end else if (reg_rd_i) begin
			reg_rdata_o <= READ_ZERO;
			if (reg_hit(reg_addr_i, ADDR_CTRL_ONE)) begin
				reg_rdata_o[WEEKLY_EN_BIT]          <= weekly_alarm_enable_q;
				reg_rdata_o[DAILY_EN_BIT]           <= daily_alarm_enable_q;
				reg_rdata_o[AUX_HI_BIT:AUX_LO_BIT]  <= aux_bits_q;
				reg_rdata_o[SEL_HI_BIT:SEL_LO_BIT]  <= periodic_select_q;
			end else if (reg_hit(reg_addr_i, ADDR_STATUS_TWO)) begin
				reg_rdata_o[PERIODIC_FLAG_BIT] <= periodic_flag;
				reg_rdata_o[WEEKLY_FLAG_BIT]   <= weekly_alarm_flag;
				reg_rdata_o[DAILY_FLAG_BIT]    <= daily_alarm_flag;
			end
		end
	end

endmodule

`default_nettype wire

// File: verif/rap_alarm_periodic_assertions.sv
// Assertion checker for the alarm and periodic interrupt unit
`timescale 1ns/1ps
`default_nettype none

module rap_alarm_periodic_assertions
	import rap_pkg::*;
(
	input wire logic       sys_clk_i,
	input wire logic       nrst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire rap_time_t  time_i,
	input wire rap_alarm_t alarm_weekly_i,
	input wire logic       osc_halt_flag_i,
	input wire logic       sec_inc_o,
	input wire logic       interrupt_out_n_oe_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	logic [7:0] ctrl_q;
	logic       armed_q;
	logic       clr_p;
	logic       lvl;
	logic       wk_hit;

	// Predicted periodic clear, per-second level mode and weekly match
	assign clr_p  = reg_wr_i && reg_addr_i == ADDR_STATUS_TWO && !reg_wdata_i[PERIODIC_FLAG_BIT];
	assign lvl    = ctrl_q[2:0] == SEL_LVL_SEC;
	assign wk_hit = ctrl_q[WEEKLY_EN_BIT] && alarm_weekly_i.weekday_mask[time_i.day_of_week]
		&& time_i.hour == alarm_weekly_i.hour && time_i.minute == alarm_weekly_i.minute;

	// Shadow of control one; the bench never writes while halt is high, so wiping on level is safe
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q  <= CTRL_ONE_RST;
			armed_q <= 1'b0;
		end else if (osc_halt_flag_i) begin
			ctrl_q <= CTRL_ONE_RST;
		end else if (reg_wr_i && reg_addr_i == ADDR_CTRL_ONE) begin
			ctrl_q  <= reg_wdata_i;
			armed_q <= armed_q || reg_wdata_i != CTRL_ONE_RST;
		end
	end

	a_ctrl_read_back: assert property (
		reg_rd_i && reg_addr_i == ADDR_CTRL_ONE && !osc_halt_flag_i |=> reg_rdata_o == $past(ctrl_q))
		else $error("Control read back wrong");
	a_status_upper_zero: assert property (
		reg_rd_i && reg_addr_i == ADDR_STATUS_TWO |=> reg_rdata_o[7:3] == 5'h00)
		else $error("Status upper bits set");
	a_weekly_alarm_fires: assert property (
		$rose(wk_hit) |-> ##[2:3] interrupt_out_n_oe_o)
		else $error("Weekly match gave no interrupt");
	a_flag_clear_releases: assert property (
		clr_p && reg_wdata_i[1:0] == 2'h0 && ctrl_q == CTRL_ONE_RST |-> ##2 !interrupt_out_n_oe_o)
		else $error("Flag clear left line low");
	a_fixed_low_out: assert property (
		ctrl_q[2:0] == SEL_LOW [*3] |-> interrupt_out_n_oe_o)
		else $error("Fixed low select not low");
	a_level_sec_falls: assert property (
		lvl && sec_inc_o |-> ##[2:3] interrupt_out_n_oe_o)
		else $error("Level output missed second");
	a_level_holds_low: assert property (
		lvl && interrupt_out_n_oe_o && !osc_halt_flag_i && !clr_p && !$past(clr_p) |=> interrupt_out_n_oe_o)
		else $error("Level output released early");
	a_idle_stays_high: assert property (
		!armed_q |-> !interrupt_out_n_oe_o)
		else $error("Output low while all disabled");

	cover property ($rose(interrupt_out_n_oe_o) && ctrl_q[2:0] == SEL_PULSE_1);
	cover property (sec_inc_o && ctrl_q[2:0] == SEL_LVL_MON);
	cover property ($rose(wk_hit));
endmodule

bind rap_alarm_periodic rap_alarm_periodic_assertions u_chk (
	.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .time_i(time_i),
	.alarm_weekly_i(alarm_weekly_i), .osc_halt_flag_i(osc_halt_flag_i), .sec_inc_o(sec_inc_o),
	.interrupt_out_n_oe_o(interrupt_out_n_oe_o)
);

`default_nettype wire

// File: verif/tb.sv
// Self-checking testbench for the alarm and periodic interrupt unit
`timescale 1ns/1ps
`default_nettype none

module tb;
	import rap_pkg::*;

	// Short second keeps the run small; quarter must still exceed the increment delay
	localparam int unsigned SEC = 7600;

	logic       clk;
	logic       nrst;
	logic [3:0] addr;
	logic       wr;
	logic       rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	rap_time_t  tm;
	rap_alarm_t alw;
	rap_alarm_t ald;
	logic       sec_wr;
	logic       halt;
	logic       inc;
	logic       drv_n;
	logic       oe;
	logic       pin;
	wire        line_n;
	int         mismatches;
	int         n_tests;

	// Open-drain line with pull-up
	assign line_n = oe ? drv_n : 1'b1;

	rap_alarm_periodic #(.SEC_CYCLES(SEC)) dut (
		.sys_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .time_i(tm), .alarm_weekly_i(alw),
		.alarm_daily_i(ald), .sec_write_i(sec_wr), .osc_halt_flag_i(halt), .adj_en_i(1'b0),
		.adj_cycles_i(18'h00000), .sec_inc_o(inc), .interrupt_out_n_i(line_n),
		.interrupt_out_n_o(drv_n), .interrupt_out_n_oe_o(oe), .pin_level_o(pin)
	);

	initial clk = 1'b0;
	always #25 clk = ~clk;

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %0h, expected %0h", $time, got, exp);
		end
	endtask

	// Inputs always move 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		addr  = a;
		wdata = d;
		wr    = 1'b1;
		tick(1);
		wr    = 1'b0;
		tick(1);
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
		addr = a;
		rd   = 1'b1;
		tick(1);
		rd   = 1'b0;
		chk(rdata, exp);
		tick(1);
	endtask

	// Bounded wait on the line enable (sel 0) or the increment (sel 1)
	task automatic wait_bit(input logic sel, input logic v);
		int n;
		n = 0;
		while ((sel ? inc : oe) !== v && n < 9000) begin
			tick(1);
			n++;
		end
		chk(sel ? inc : oe, v);
	endtask

	// Restart the divider, then time one full low phase of the pulse output
	task automatic pulse(input logic [2:0] code, input int low, input logic inc_chk);
		int n;
		int at;
		wr_reg(ADDR_CTRL_ONE, {5'h00, code});
		sec_wr = 1'b1;
		tick(1);
		sec_wr = 1'b0;
		tick(3);
		chk(oe, 1'b1);
		wait_bit(1'b0, 1'b0);
		wait_bit(1'b0, 1'b1);
		n  = 0;
		at = 0;
		while (oe === 1'b1 && n < 9000) begin
			if (inc === 1'b1)
				at = n;
			tick(1);
			n++;
		end
		chk(n, low);
		if (inc_chk)
			chk(at > 1834 && at < 1846, 1'b1);
		wr_reg(ADDR_CTRL_ONE, 8'h00);
	endtask

	// One level-mode period: fires or not, holds, then clears
	task automatic lvl(input logic [2:0] code, input logic exp);
		wr_reg(ADDR_CTRL_ONE, {5'h00, code});
		wait_bit(1'b1, 1'b1);
		tick(4);
		chk(oe, exp);
		tick(50);
		chk(oe, exp);
		rd_reg(ADDR_STATUS_TWO, {5'h00, exp, 2'h0});
		wr_reg(ADDR_STATUS_TWO, 8'h00);
		tick(2);
		chk(oe, 1'b0);
		wr_reg(ADDR_CTRL_ONE, 8'h00);
	endtask

	initial begin
		#(90000 * 50);
		mismatches++;
		end_of_test();
	end

	initial begin
		mismatches = 0;
		n_tests    = 0;
		nrst   = 1'b0;
		addr   = 4'h0;
		wr     = 1'b0;
		rd     = 1'b0;
		wdata  = 8'h00;
		sec_wr = 1'b0;
		halt   = 1'b0;
		tm     = '{3'h3, 6'h10, 7'h30, 7'h00, 6'h05};
		alw    = '{7'h08, 6'h10, 7'h30};
		ald    = '{7'h00, 6'h11, 7'h45};
		tick(16);
		nrst = 1'b1;
		tick(1);
		chk(oe, 1'b0);
		rd_reg(ADDR_CTRL_ONE, CTRL_ONE_RST);
		rd_reg(4'h3, READ_ZERO);
		wr_reg(ADDR_STATUS_TWO, 8'hFF);
		rd_reg(ADDR_STATUS_TWO, READ_ZERO);
		// Weekly alarm, write-one keeps, write-zero clears, then re-arms
		wr_reg(ADDR_CTRL_ONE, 8'h80);
		tick(10);
		chk(pin, 1'b0);
		rd_reg(ADDR_STATUS_TWO, 8'h02);
		tm.minute = 7'h31;
		wr_reg(ADDR_STATUS_TWO, 8'h02);
		rd_reg(ADDR_STATUS_TWO, 8'h02);
		wr_reg(ADDR_STATUS_TWO, 8'h00);
		tick(2);
		chk(oe, 1'b0);
		rd_reg(ADDR_CTRL_ONE, 8'h80);
		tm.minute = 7'h30;
		// Match edge and a clear land on one edge: the new event must survive
		wr_reg(ADDR_STATUS_TWO, 8'h00);
		tick(4);
		chk(oe, 1'b1);
		// Daily alarm on a weekday the weekly mask excludes; both flags share the line
		tm = '{3'h5, 6'h11, 7'h45, 7'h00, 6'h05};
		wr_reg(ADDR_CTRL_ONE, 8'hC0);
		tick(4);
		rd_reg(ADDR_STATUS_TWO, 8'h03);
		tm.minute = 7'h46;
		wr_reg(ADDR_STATUS_TWO, 8'h01);
		tick(2);
		chk(oe, 1'b1);
		wr_reg(ADDR_CTRL_ONE, 8'h00);
		wr_reg(ADDR_STATUS_TWO, 8'h00);
		tick(2);
		chk(oe, 1'b0);
		// Fixed select codes, then pulse modes
		wr_reg(ADDR_CTRL_ONE, {5'h00, SEL_LOW});
		tick(3);
		chk(oe, 1'b1);
		wr_reg(ADDR_CTRL_ONE, {5'h00, SEL_OFF});
		tick(3);
		chk(oe, 1'b0);
		pulse(SEL_PULSE_1, SEC / 2, 1'b1);
		pulse(SEL_PULSE_2, SEC / 4, 1'b0);
		// Level codes at the first instant of a month, then off the minute boundary
		tm = '{3'h2, 6'h00, 7'h00, 7'h00, 6'h01};
		for (int c = 4; c < 8; c++)
			lvl(c[2:0], 1'b1);
		tm.second = 7'h01;
		lvl(SEL_LVL_MIN, 1'b0);
		// Halt wipes enables, select and flags
		wr_reg(ADDR_CTRL_ONE, 8'hC4);
		wait_bit(1'b1, 1'b1);
		tick(4);
		halt = 1'b1;
		tick(3);
		halt = 1'b0;
		tick(3);
		rd_reg(ADDR_CTRL_ONE, READ_ZERO);
		rd_reg(ADDR_STATUS_TWO, READ_ZERO);
		chk(oe, 1'b0);
		end_of_test();
	end
endmodule

`default_nettype wire
